//--- rtl/pllq_top.sv
// PLL lock qualifier: configuration registers for the lock detector, the
// precision thresholds and the loop filter third pole, plus lock debounce,
// calibration gating, one-time latch and status pin select.
// Assumes lock inputs and calibration done are synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module pllq_top
    import pllq_pkg::*;
#(
    parameter logic [15:0] CYC_SHORT = DEB_CYC_SHORT,
    parameter logic [15:0] CYC_MID = DEB_CYC_MID,
    parameter logic [15:0] CYC_LONG = DEB_CYC_LONG
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register access port
    input wire logic [REG_IDX_W-1:0] reg_sel,
    input wire logic reg_wr_en,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [REG_DATA_W-1:0] reg_rdata,
    // Analog detector and calibration
    input wire logic lock_orig_in,
    input wire logic lock_precise_in,
    input wire logic vco_cal_done,
    // Lock results
    output logic pll_lock,
    output logic lock_status_pin,
    // Analog settings
    output logic precision_detector_en,
    output logic [3:0] precision_high_threshold,
    output logic [3:0] precision_low_threshold,
    output logic [2:0] lock_filter_res_sel,
    output logic third_pole_bypass,
    output logic [2:0] third_pole_resistor_sel,
    output logic [2:0] third_pole_capacitor_sel
);
    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Interval for a timer code; decoding kept in one place
    function automatic logic [15:0] timer_limit(input logic [1:0] code);
        case (code)
            TMR_NONE: timer_limit = 16'h0000;
            TMR_SHORT: timer_limit = CYC_SHORT;
            TMR_MID: timer_limit = CYC_MID;
            default: timer_limit = CYC_LONG;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    logic tp_bypass_q, tp_bypass_d;
    logic [2:0] tp_res_q, tp_res_d, tp_cap_q, tp_cap_d;
    logic raw_sel_q, raw_sel_d, prec_en_q, prec_en_d;
    logic [1:0] timer_q, timer_d;
    logic oneshot_q, oneshot_d, calbyp_q, calbyp_d, disable_q, disable_d;
    logic [2:0] filt_q, filt_d;
    logic [3:0] th_high_q, th_high_d, th_low_q, th_low_d;

    // Writes land on defined fields only; bits outside them are dropped
    always_comb begin
        tp_bypass_d = tp_bypass_q;
        tp_res_d = tp_res_q;
        tp_cap_d = tp_cap_q;
        raw_sel_d = raw_sel_q;
        prec_en_d = prec_en_q;
        timer_d = timer_q;
        oneshot_d = oneshot_q;
        calbyp_d = calbyp_q;
        disable_d = disable_q;
        filt_d = filt_q;
        th_high_d = th_high_q;
        th_low_d = th_low_q;
        if (reg_wr_en) begin
            case (reg_sel)
                IDX_THIRD_POLE: begin
                    tp_bypass_d = reg_wdata[TP_BYPASS_BIT];
                    tp_res_d = reg_wdata[TP_RES_LSB +: 3];
                    tp_cap_d = reg_wdata[TP_CAP_LSB +: 3];
                end
                IDX_LOCK_CFG: begin
                    raw_sel_d = reg_wdata[LK_RAW_SEL_BIT];
                    prec_en_d = reg_wdata[LK_PREC_EN_BIT];
                    timer_d = reg_wdata[LK_TIMER_LSB +: 2];
                    oneshot_d = reg_wdata[LK_ONESHOT_BIT];
                    calbyp_d = reg_wdata[LK_CALBYP_BIT];
                    disable_d = reg_wdata[LK_DISABLE_BIT];
                    filt_d = reg_wdata[LK_FILT_LSB +: 3];
                end
                IDX_THRESH: begin
                    th_high_d = reg_wdata[TH_HIGH_LSB +: 4];
                    th_low_d = reg_wdata[TH_LOW_LSB +: 4];
                end
                default: begin
                    // Status index is read only
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tp_bypass_q <= TP_BYPASS_RST;
            tp_res_q <= TP_RES_RST;
            tp_cap_q <= TP_CAP_RST;
            raw_sel_q <= LK_RAW_SEL_RST;
            prec_en_q <= LK_PREC_EN_RST;
            timer_q <= LK_TIMER_RST;
            oneshot_q <= LK_ONESHOT_RST;
            calbyp_q <= LK_CALBYP_RST;
            disable_q <= LK_DISABLE_RST;
            filt_q <= LK_FILT_RST;
            th_high_q <= TH_HIGH_RST;
            th_low_q <= TH_LOW_RST;
        end else begin
            tp_bypass_q <= tp_bypass_d;
            tp_res_q <= tp_res_d;
            tp_cap_q <= tp_cap_d;
            raw_sel_q <= raw_sel_d;
            prec_en_q <= prec_en_d;
            timer_q <= timer_d;
            oneshot_q <= oneshot_d;
            calbyp_q <= calbyp_d;
            disable_q <= disable_d;
            filt_q <= filt_d;
            th_high_q <= th_high_d;
            th_low_q <= th_low_d;
        end
    end

    // -------------------------------------------------------------------
    // Lock qualification
    // -------------------------------------------------------------------
    logic raw_lock, det_en, deb_stable;
    logic latch_q, latch_d, lock_q, lock_d, pin_q, pin_d;

    // Precision detector or original detector as raw source
    assign raw_lock = prec_en_q ? lock_precise_in : lock_orig_in;
    // Detection waits for calibration unless bypassed; disable stops it
    assign det_en = !disable_q && (calbyp_q || vco_cal_done);

    pllq_debounce #(
        .CNT_W(DEB_CNT_W)
    ) u_debounce (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .lock_in(raw_lock && det_en),
        .limit(timer_limit(timer_q)),
        .stable(deb_stable)
    );

    // Latch, lock and pin next values; one flop each so outputs are clean
    always_comb begin
        latch_d = latch_q;
        if (!oneshot_q || disable_q) begin
            latch_d = 1'b0;
        end else if (deb_stable) begin
            latch_d = 1'b1;
        end
        if (disable_q) begin
            lock_d = 1'b1;
        end else if (oneshot_q) begin
            lock_d = latch_q || deb_stable;
        end else begin
            lock_d = deb_stable;
        end
        // Raw view is useful for bench tuning but skips the debounce
        pin_d = raw_sel_q ? raw_lock : lock_d;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            latch_q <= 1'b0;
            lock_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            lock_q <= lock_d;
            pin_q <= pin_d;
        end
    end

    // -------------------------------------------------------------------
    // Register read-back
    // -------------------------------------------------------------------
    logic [REG_DATA_W-1:0] rdata_q, rdata_d;

    // Registered read; reserved bits are zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            rdata_d = '0;
            case (reg_sel)
                IDX_THIRD_POLE: begin
                    rdata_d[TP_BYPASS_BIT] = tp_bypass_q;
                    rdata_d[TP_RES_LSB +: 3] = tp_res_q;
                    rdata_d[TP_CAP_LSB +: 3] = tp_cap_q;
                end
                IDX_LOCK_CFG: begin
                    rdata_d[LK_RAW_SEL_BIT] = raw_sel_q;
                    rdata_d[LK_PREC_EN_BIT] = prec_en_q;
                    rdata_d[LK_TIMER_LSB +: 2] = timer_q;
                    rdata_d[LK_ONESHOT_BIT] = oneshot_q;
                    rdata_d[LK_CALBYP_BIT] = calbyp_q;
                    rdata_d[LK_DISABLE_BIT] = disable_q;
                    rdata_d[LK_FILT_LSB +: 3] = filt_q;
                end
                IDX_THRESH: begin
                    rdata_d[TH_HIGH_LSB +: 4] = th_high_q;
                    rdata_d[TH_LOW_LSB +: 4] = th_low_q;
                end
                default: begin
                    rdata_d[ST_LOCK_BIT] = lock_q;
                    rdata_d[ST_RAW_BIT] = raw_lock;
                    rdata_d[ST_DET_EN_BIT] = det_en;
                    rdata_d[ST_LATCH_BIT] = latch_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_q;
    assign pll_lock = lock_q;
    assign lock_status_pin = pin_q;
    assign precision_detector_en = prec_en_q;
    assign precision_high_threshold = th_high_q;
    assign precision_low_threshold = th_low_q;
    assign lock_filter_res_sel = filt_q;
    assign third_pole_bypass = tp_bypass_q;
    assign third_pole_resistor_sel = tp_res_q;
    assign third_pole_capacitor_sel = tp_cap_q;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_disable_forces_lock: assert property (disable_q |=> pll_lock)
        else $error("lock not forced while detector disabled");
    a_oneshot_holds: assert property (
        oneshot_q && latch_q && !disable_q && $stable(oneshot_q) |=> pll_lock)
        else $error("one-time lock dropped");
    a_realtime_drop: assert property (
        !oneshot_q && !disable_q && !raw_lock |=> !pll_lock)
        else $error("real-time lock did not follow detector drop");
    a_cal_gate: assert property (
        !disable_q && !calbyp_q && !vco_cal_done && !latch_q |=> !pll_lock)
        else $error("lock asserted during calibration");
    a_no_delay_lock: assert property (
        timer_q == TMR_NONE && det_en && raw_lock && !disable_q |=> pll_lock)
        else $error("zero interval did not pass lock");
    // Three high cycles never reach a short interval of three or more cycles
    a_short_wait: assert property (
        timer_q == TMR_SHORT && !oneshot_q && !disable_q && $rose(raw_lock && det_en)
        ##0 (raw_lock && det_en && timer_q == TMR_SHORT) [*3] |=> !pll_lock)
        else $error("lock asserted before debounce interval");
    a_pin_raw: assert property (raw_sel_q |=> lock_status_pin == $past(raw_lock))
        else $error("status pin not showing raw lock");
    a_latch_clear: assert property (!oneshot_q || disable_q |=> !latch_q)
        else $error("one-time latch not cleared");
    a_thresh_write: assert property (reg_wr_en && reg_sel == IDX_THRESH
        |=> precision_high_threshold == $past(reg_wdata[7:4]))
        else $error("high threshold not taken");
    a_reserved_zero: assert property (reg_rd_en && reg_sel == IDX_THIRD_POLE
        |=> reg_rdata[15:8] == 8'h00 && reg_rdata[3] == 1'b0)
        else $error("reserved bits read nonzero");

    c_oneshot_latched: cover property (oneshot_q && latch_q && !raw_lock);
    c_lock_rise: cover property (!disable_q ##1 $rose(pll_lock));
    c_forced_lock: cover property (disable_q && pll_lock && !raw_lock);
    c_raw_pin: cover property (raw_sel_q && lock_status_pin && !pll_lock);
endmodule // pllq_top
`default_nettype wire

//--- inc/pllq_pkg.sv
// Constants for the PLL lock qualifier: register indices, field layout,
// reset values and debounce counts. Assumes a single 250 MHz system clock.
//
// How it works
// - Debounce lock over 0, 570, 5700 or 57000 cycles; timer resets to 2.
// - Real-time mode follows detector; one-time mode holds lock after first assertion.
// - One-time mode with lock seen keeps lock high despite later unlock.
// - Detection waits for calibration done unless calibration bypass is set.
// - Detector-disable bit forces lock high and stops detection.
// - Raw-lock select routes the raw selected lock to the status pin.
// - Precision-enable (reset 1) picks the precision detector as lock source.
// - High threshold held in bits 7:4, reset 8, driven to upper comparator.
// - Low threshold held in bits 3:0, reset 8, driven to lower comparator.
// - Lock filter resistor select in bits 2:0, reset 0, driven unchanged.
// - Third-pole resistor in bits 6:4, reset 3, driven to loop filter.
// - Third-pole capacitor in bits 2:0, reset 7, driven to loop filter.
// - Calibration-done is 0 while calibrating, 1 after; gates detection.
`default_nettype none
package pllq_pkg;
    // -------------------------------------------------------------------
    // Register indices
    // -------------------------------------------------------------------
    localparam int REG_IDX_W = 2;
    localparam logic [1:0] IDX_THIRD_POLE = 2'h0;
    localparam logic [1:0] IDX_LOCK_CFG = 2'h1;
    localparam logic [1:0] IDX_THRESH = 2'h2;
    localparam logic [1:0] IDX_STATUS = 2'h3;
    localparam int REG_DATA_W = 16;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int TP_BYPASS_BIT = 7;
    localparam int TP_RES_LSB = 4;
    localparam int TP_CAP_LSB = 0;
    localparam int LK_RAW_SEL_BIT = 9;
    localparam int LK_PREC_EN_BIT = 8;
    localparam int LK_TIMER_LSB = 6;
    localparam int LK_ONESHOT_BIT = 5;
    localparam int LK_CALBYP_BIT = 4;
    localparam int LK_DISABLE_BIT = 3;
    localparam int LK_FILT_LSB = 0;
    localparam int TH_HIGH_LSB = 4;
    localparam int TH_LOW_LSB = 0;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_RAW_BIT = 1;
    localparam int ST_DET_EN_BIT = 2;
    localparam int ST_LATCH_BIT = 3;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic TP_BYPASS_RST = 1'h0;
    localparam logic [2:0] TP_RES_RST = 3'h3;
    localparam logic [2:0] TP_CAP_RST = 3'h7;
    localparam logic LK_RAW_SEL_RST = 1'h0;
    localparam logic LK_PREC_EN_RST = 1'h1;
    localparam logic [1:0] LK_TIMER_RST = 2'h2;
    localparam logic LK_ONESHOT_RST = 1'h0;
    localparam logic LK_CALBYP_RST = 1'h0;
    localparam logic LK_DISABLE_RST = 1'h0;
    localparam logic [2:0] LK_FILT_RST = 3'h0;
    localparam logic [3:0] TH_HIGH_RST = 4'h8;
    localparam logic [3:0] TH_LOW_RST = 4'h8;

    // -------------------------------------------------------------------
    // Debounce timer codes and counts (system clock cycles)
    // -------------------------------------------------------------------
    localparam logic [1:0] TMR_NONE = 2'h0;
    localparam logic [1:0] TMR_SHORT = 2'h1;
    localparam logic [1:0] TMR_MID = 2'h2;
    localparam logic [1:0] TMR_LONG = 2'h3;
    localparam int DEB_CNT_W = 16;
    localparam logic [15:0] DEB_CYC_SHORT = 16'h023A; // 570
    localparam logic [15:0] DEB_CYC_MID = 16'h1644; // 5700
    localparam logic [15:0] DEB_CYC_LONG = 16'hDEA8; // 57000
endpackage
`default_nettype wire

//--- rtl/pllq_debounce.sv
// Debounce counter for the raw lock indication.
// Assumes limit is held steady while counting; a change simply restarts nothing.
`timescale 1ns/100ps
`default_nettype none
module pllq_debounce #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Qualify input and interval
    input wire logic lock_in,
    input wire logic [CNT_W-1:0] limit,
    // Stable result, combinational from the count
    output logic stable
);
    logic [CNT_W-1:0] cnt_q, cnt_d;

    // Count while input is high, saturate at limit, restart on any drop
    always_comb begin
        if (!lock_in) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Limit zero passes the input straight through
    assign stable = lock_in && (cnt_q >= limit);

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_deb_drop_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
        !lock_in |=> cnt_q == '0)
        else $error("debounce count not cleared after input drop");
    a_deb_no_early: assert property (@(posedge clk_sys) disable iff (!rstn)
        stable && limit != '0 |-> $past(lock_in))
        else $error("debounce reported stable before interval");
endmodule // pllq_debounce
`default_nettype wire

//--- testbench/pllq_analog_model.sv
// Behavioural stand-in for the analog lock comparators and VCO calibration.
// Assumes the bench drives its commands just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module pllq_analog_model #(
    parameter int CAL_CYC = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Commands from the bench
    input wire logic want_lock,
    input wire logic [2:0] prec_lag,
    input wire logic [2:0] orig_lag,
    input wire logic cal_start,
    // Comparator and calibration outputs
    output logic lock_orig_in,
    output logic lock_precise_in,
    output logic vco_cal_done
);
    logic [7:0] hist_q, hist_d;
    int cal_q, cal_d;
    // Next state: lock history and calibration countdown, which restarts on request
    always_comb begin
        hist_d = {hist_q[6:0], want_lock};
        cal_d = cal_start ? CAL_CYC : (cal_q > 0 ? cal_q - 1 : 0);
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hist_q <= 8'h00;
            cal_q <= CAL_CYC;
        end else begin
            hist_q <= hist_d;
            cal_q <= cal_d;
        end
    end
    // Each detector lags the true lock by its own delay, so the two can disagree
    assign lock_precise_in = (prec_lag == 3'h0) ? want_lock : hist_q[prec_lag - 3'h1];
    assign lock_orig_in = (orig_lag == 3'h0) ? want_lock : hist_q[orig_lag - 3'h1];
    assign vco_cal_done = (cal_q == 0);
endmodule // pllq_analog_model
`default_nettype wire

//--- testbench/tb_pll_lock_qualifier.sv
// Self-checking bench: a cycle model of the qualifier is compared every clock.
// Assumes the short debounce counts 3/5/7 set at the instance below.
`timescale 1ns/100ps
`default_nettype none
module tb_pll_lock_qualifier;
    import pllq_pkg::*;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic clk_sys = 1'b0, rstn = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic want = 1'b0, cal_go = 1'b0, live = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [2:0] plag = 3'h0, olag = 3'h0;
    logic lock_orig_in, lock_precise_in, vco_cal_done, pll_lock, lock_status_pin;
    logic precision_detector_en, third_pole_bypass;
    logic [3:0] precision_high_threshold, precision_low_threshold;
    logic [2:0] lock_filter_res_sel, third_pole_resistor_sel, third_pole_capacitor_sel;
    logic [15:0] m_tp, m_lk, m_th, m_rd;
    logic m_lock, m_pin, m_latch, raw, det, hit, nl;
    int bad_count = 0, n_checks = 0, seed = 50, n, m_cnt, lim;

    pllq_top #(.CYC_SHORT(16'h0003), .CYC_MID(16'h0005), .CYC_LONG(16'h0007)) i_pllq_top (
        .clk_sys(clk_sys), .rstn(rstn), .reg_sel(reg_sel), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .lock_orig_in(lock_orig_in), .lock_precise_in(lock_precise_in),
        .vco_cal_done(vco_cal_done), .pll_lock(pll_lock), .lock_status_pin(lock_status_pin),
        .precision_detector_en(precision_detector_en),
        .precision_high_threshold(precision_high_threshold),
        .precision_low_threshold(precision_low_threshold),
        .lock_filter_res_sel(lock_filter_res_sel), .third_pole_bypass(third_pole_bypass),
        .third_pole_resistor_sel(third_pole_resistor_sel),
        .third_pole_capacitor_sel(third_pole_capacitor_sel));
    pllq_analog_model i_pllq_analog_model (.clk_sys(clk_sys), .rstn(rstn), .want_lock(want),
        .prec_lag(plag), .orig_lag(olag), .cal_start(cal_go), .lock_orig_in(lock_orig_in),
        .lock_precise_in(lock_precise_in), .vco_cal_done(vco_cal_done));

    initial forever #2 clk_sys = ~clk_sys;

    function automatic int lim_of(input logic [1:0] t);
        return (t == 2'h0) ? 0 : (t == 2'h1) ? 3 : (t == 2'h2) ? 5 : 7;
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ------------------------------------------------------------------
    // Cycle model: all values taken from state before the edge
    // ------------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            m_tp = 16'h0037;
            m_lk = 16'h0180;
            m_th = 16'h0088;
            m_rd = 16'h0000;
            m_cnt = 0;
            m_lock = 1'b0;
            m_pin = 1'b0;
            m_latch = 1'b0;
        end else begin
            raw = m_lk[8] ? lock_precise_in : lock_orig_in;
            det = !m_lk[3] && (m_lk[4] || vco_cal_done);
            lim = lim_of(m_lk[7:6]);
            hit = raw && det && (m_cnt >= lim);
            if (reg_rd_en) begin
                m_rd = (reg_sel == 2'h0) ? m_tp : (reg_sel == 2'h1) ? m_lk :
                       (reg_sel == 2'h2) ? m_th : {12'h000, m_latch, det, raw, m_lock};
            end
            nl = m_lk[3] || (m_lk[5] && m_latch) || hit; // Latch only counts while one-time is on
            m_latch = m_lk[5] && !m_lk[3] && (m_latch || hit);
            m_pin = m_lk[9] ? raw : nl;
            m_lock = nl;
            m_cnt = !(raw && det) ? 0 : (m_cnt >= lim) ? m_cnt : m_cnt + 1; // Saturates at limit
            if (reg_wr_en && reg_sel == 2'h0) m_tp = reg_wdata & 16'h00F7;
            if (reg_wr_en && reg_sel == 2'h1) m_lk = reg_wdata & 16'h03FF;
            if (reg_wr_en && reg_sel == 2'h2) m_th = reg_wdata & 16'h00FF;
        end
    end

    // Every output against the model once per cycle
    always @(negedge clk_sys) begin
        if (live) begin
            chk("pll_lock", 16'(pll_lock), 16'(m_lock));
            chk("status_pin", 16'(lock_status_pin), 16'(m_pin));
            chk("reg_rdata", reg_rdata, m_rd);
            chk("thresholds", {7'h00, precision_detector_en, precision_high_threshold,
                precision_low_threshold}, {7'h00, m_lk[8], m_th[7:0]});
            chk("filter", {6'h00, lock_filter_res_sel, third_pole_bypass, third_pole_resistor_sel,
                third_pole_capacitor_sel}, {6'h00, m_lk[2:0], m_tp[7:4], m_tp[2:0]});
        end
    end

    // ------------------------------------------------------------------
    // Register port tasks: strobe one cycle, then one idle cycle
    // ------------------------------------------------------------------
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        reg_sel = s;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [1:0] s);
        reg_sel = s;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        @(negedge clk_sys);
    endtask

    // Lock config: timer, one-shot, cal bypass, disable, precision, raw select
    task automatic cfg(input logic [1:0] t, input logic os, input logic cb, input logic ds,
                       input logic pe, input logic rs);
        logic [2:0] f;
        f = 3'($random(seed));
        wr(2'h1, {6'h00, rs, pe, t, os, cb, ds, f});
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(5000 * 4);
        bad_count++;
        $display("ERROR watchdog expired");
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        wait_n(10);
        rstn = 1'b1;
        live = 1'b1;
        rd(2'h0);
        rd(2'h1);
        rd(2'h2);
        wr(2'h3, 16'hFFFF);
        rd(2'h3);
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            wr(2'(i % 3), 16'($random(seed)) & 16'hFF7F); // bypass kept clear here
            rd(2'(i % 3));
        end
        wr(2'h0, 16'h00B5); // model keeps bit 7 of the third-pole register, so bypass may be set
        rd(2'h0);
        $display("test registers done");
        for (int t = 0; t < 4; t++) begin
            cfg(2'(t), 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
            want = 1'b1;
            n = 0;
            while (pll_lock !== 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            chk("lock_delay", 16'(n), 16'(lim_of(2'(t)) + 1));
            want = 1'b0;
            wait_n(3);
            if (t > 0) begin
                want = 1'b1;
                wait_n(lim_of(2'(t)));
                want = 1'b0;
                chk("short_burst", 16'(pll_lock), 16'h0000);
                wait_n(3);
            end
        end
        $display("test debounce done");
        cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        want = 1'b1;
        cal_go = 1'b1;
        wait_n(1);
        cal_go = 1'b0;
        wait_n(5);
        chk("cal_gate", 16'(pll_lock), 16'h0000);
        wait_n(25);
        chk("cal_done", 16'(pll_lock), 16'h0001);
        cfg(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        cal_go = 1'b1;
        wait_n(1);
        cal_go = 1'b0;
        wait_n(5);
        chk("cal_bypass", 16'(pll_lock), 16'h0001);
        want = 1'b0;
        wait_n(25);
        $display("test calibration done");
        cfg(2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        want = 1'b1;
        wait_n(8);
        want = 1'b0;
        wait_n(4);
        chk("one_shot_hold", 16'(pll_lock), 16'h0001);
        rd(2'h3);
        cfg(2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        wait_n(2);
        chk("one_shot_off", 16'(pll_lock), 16'h0000);
        cfg(2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        want = 1'b1;
        wait_n(8);
        want = 1'b0;
        cfg(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        chk("forced", 16'(pll_lock), 16'h0001);
        cfg(2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        wait_n(2);
        chk("latch_clear", 16'(pll_lock), 16'h0000);
        $display("test one-shot and disable done");
        olag = 3'h5;
        cfg(2'h3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        want = 1'b1;
        wait_n(3);
        chk("raw_pin", 16'(lock_status_pin), 16'h0001);
        chk("raw_qual", 16'(pll_lock), 16'h0000);
        want = 1'b0;
        cfg(2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        wait_n(2);
        chk("orig_src", 16'(lock_status_pin), 16'h0001);
        wait_n(8);
        $display("test raw select done");
        for (int i = 0; i < 300; i++) begin
            want = 1'($random(seed));
            if (i % 50 == 0) begin
                plag = 3'($random(seed));
                olag = 3'($random(seed));
                cfg(2'($random(seed)), 1'b0, 1'b1, 1'($random(seed)), 1'($random(seed)),
                    1'($random(seed)));
            end
            wait_n(1);
        end
        $display("test random chatter done");
        wrap_up();
    end
endmodule // tb_pll_lock_qualifier
`default_nettype wire
